// [include/ats_pkg.sv]
// Package for the asynchronous-capable 8-bit timer register block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package ats_pkg;
    localparam int DATA_W = 8;
    localparam int APB_AW = 8;

    // Register byte addresses
    localparam logic [APB_AW-1:0] OFS_COUNTER = 8'h00;
    localparam logic [APB_AW-1:0] OFS_COMPARE = 8'h04;
    localparam logic [APB_AW-1:0] OFS_CONTROL = 8'h08;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_IRQ_EN = 8'h10;
    localparam logic [APB_AW-1:0] OFS_FLAGS = 8'h14;

    // async_status fields
    localparam int BIT_SRC_SEL = 3;
    localparam int BIT_CNT_BUSY = 2;
    localparam int BIT_CMP_BUSY = 1;
    localparam int BIT_CTL_BUSY = 0;

    // timer_control fields
    localparam int BIT_FORCE = 7;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_CS_HI = 2;

    // Enable and flag fields
    localparam int BIT_CMP = 7;
    localparam int BIT_OVF = 6;

    // Reset value and counter maximum
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] CNT_MAX = 8'hFF;

    // Index of each holding unit, and their count
    localparam int IDX_CNT = 0;
    localparam int IDX_CMP = 1;
    localparam int IDX_CTL = 2;
    localparam int NUM_HOLD = 3;

    // Timing counts
    localparam int XFER_EDGES = 2;
    localparam int FLAG_SYNC_CYCLES = 3;
    localparam int WAKE_HALT_CYCLES = 4;

    typedef enum logic [1:0] {
        ATS_OUT_OFF,
        ATS_OUT_TOGGLE,
        ATS_OUT_CLEAR,
        ATS_OUT_SET
    } ats_out_mode_t;

    typedef enum logic [1:0] {
        ATS_WAKE_IDLE,
        ATS_WAKE_PEND,
        ATS_WAKE_HALT
    } ats_wake_t;
endpackage : ats_pkg

// [rtl/ats_hold.sv]
// Temporary holding register with update-busy flag for one timer register.
// Assumes osc_edge is a one-cycle pulse per rising oscillator edge.
module ats_hold
    import ats_pkg::*;
#(
    parameter int XFER = XFER_EDGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_mode,
    input wire logic wr,
    input wire logic [ats_pkg::DATA_W-1:0] wdata,
    input wire logic osc_edge,
    output logic [ats_pkg::DATA_W-1:0] hold,
    output logic busy,
    output logic load
);
    logic [1:0] edges;
    logic done;

    // Second oscillator edge after the write completes the transfer
    assign done = busy && osc_edge && (edges == 2'(XFER - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= RST_BYTE;
        end else if (wr) begin
            hold <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            edges <= 2'b00;
        end else if (wr && async_mode) begin
            busy <= 1'b1;
            edges <= 2'b00;
        end else if (done) begin
            busy <= 1'b0;
            edges <= 2'b00;
        end else if (busy && osc_edge) begin
            edges <= edges + 2'b01;
        end
    end

    // Transfer-complete event returns to the bus side as the busy clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load <= 1'b0;
        end else begin
            load <= (wr && !async_mode) || done;
        end
    end
endmodule // ats_hold

// [rtl/ats_timer.sv]
// 8-bit timer with synchronous or oscillator-pin clocking, APB registers.
// Assumes osc_pin and the sleep/vector inputs are synchronous to clk.
//
// How it works
// - Counter register is readable and writable by software at any time.
// - A counter write suppresses the compare match on the next timer tick.
// - Compare register is compared with the counter; equality gives a match.
// - Status bit 3 selects I/O clock at zero, oscillator pin at one.
// - Changing the source bit may leave timer registers undefined.
// - Async counter write sets busy bit 2 until the counter is loaded.
// - Async compare write sets busy bit 1 until compare is loaded.
// - Async control write sets busy bit 0 until control is loaded.
// - Counter reads give the timer value; compare and control give holding values, control bit 7 reading as zero.
// - Async writes land in a holding register, moved after two oscillator edges.
// - Each of the three registers has its own independent holding register.
// - Compare matches are disabled while counter or compare transfer is pending.
// - Wake logic needs one oscillator cycle to rearm after a wake-up.
// - Wake-up starts on the timer tick after the interrupt condition.
// - After a timer wake-up the processor is halted for four cycles.
// - Async counter reads use a copy refreshed one cycle after each oscillator edge.
// - Async flag synchronisation takes three clock cycles plus one timer tick.
// - The compare output pin changes on the timer tick itself.
// - Compare flag sets on match; clears on vector entry or written one.
// - Overflow flag sets on overflow; clears on vector entry or written one.
//
// The APB slave port and the address map were left to the implementer.
module ats_timer #(
    parameter int SYNC_STAGES = ats_pkg::FLAG_SYNC_CYCLES,
    parameter int HALT_CYCLES = ats_pkg::WAKE_HALT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ats_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscillator_input_pin,
    input wire logic sleep_active,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    output logic compare_output_pin,
    output logic compare_irq,
    output logic overflow_irq,
    output logic wake_request,
    output logic cpu_halt
);
    import ats_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n;
    logic clock_source_select;
    logic osc_prev;
    logic osc_edge;
    logic osc_edge_d;
    logic tick;
    logic setup;
    logic wr_access;
    logic [NUM_HOLD-1:0] wr_hold;
    logic [NUM_HOLD-1:0] busy;
    logic [NUM_HOLD-1:0] load;
    logic [DATA_W-1:0] hold [NUM_HOLD];
    logic [DATA_W-1:0] counter_value;
    logic [DATA_W-1:0] counter_view;
    logic [DATA_W-1:0] compare_value;
    logic [DATA_W-1:0] timer_control;
    logic [DATA_W-1:0] rd_byte;
    logic rd_err;
    logic running;
    logic block_match;
    logic match_evt;
    logic ovf_evt;
    logic [SYNC_STAGES-1:0] match_pipe;
    logic [SYNC_STAGES-1:0] ovf_pipe;
    logic match_set;
    logic ovf_set;
    logic compare_match_flag;
    logic overflow_flag;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic flag_clr_cmp;
    logic flag_clr_ovf;
    ats_out_mode_t out_mode;
    ats_wake_t wake_state;
    logic wake_armed;
    logic wake_cond;
    logic [2:0] halt_cnt;

    // Reset released through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Oscillator pin is sampled, not used as a clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev <= 1'b0;
            osc_edge_d <= 1'b0;
        end else begin
            osc_prev <= oscillator_input_pin;
            osc_edge_d <= osc_edge;
        end
    end
    assign osc_edge = oscillator_input_pin && !osc_prev;
    assign tick = clock_source_select ? osc_edge : 1'b1;

    // APB decode; zero wait states, read data captured in setup, writes land in access
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite && !rd_err;
    assign pready = 1'b1;

    always_comb begin
        rd_byte = RST_BYTE;
        rd_err = 1'b0;
        if (paddr == OFS_COUNTER) begin
            rd_byte = clock_source_select ? counter_view : counter_value;
        end else if (paddr == OFS_COMPARE) begin
            rd_byte = hold[IDX_CMP];
        end else if (paddr == OFS_CONTROL) begin
            rd_byte = hold[IDX_CTL] & ~(8'h01 << BIT_FORCE);
        end else if (paddr == OFS_STATUS) begin
            rd_byte[BIT_SRC_SEL] = clock_source_select;
            rd_byte[BIT_CNT_BUSY] = busy[IDX_CNT];
            rd_byte[BIT_CMP_BUSY] = busy[IDX_CMP];
            rd_byte[BIT_CTL_BUSY] = busy[IDX_CTL];
        end else if (paddr == OFS_IRQ_EN) begin
            rd_byte[BIT_CMP] = compare_irq_enable;
            rd_byte[BIT_OVF] = overflow_irq_enable;
        end else if (paddr == OFS_FLAGS) begin
            rd_byte[BIT_CMP] = compare_match_flag;
            rd_byte[BIT_OVF] = overflow_flag;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr <= rd_err;
        end
    end

    // Clock source select; busy bits at this address are read-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_select <= 1'b0;
        end else if (wr_access && paddr == OFS_STATUS) begin
            clock_source_select <= pwdata[BIT_SRC_SEL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_irq_enable <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else if (wr_access && paddr == OFS_IRQ_EN) begin
            compare_irq_enable <= pwdata[BIT_CMP];
            overflow_irq_enable <= pwdata[BIT_OVF];
        end
    end

    // Per-register holding units, fully independent of each other
    assign wr_hold[IDX_CNT] = wr_access && paddr == OFS_COUNTER;
    assign wr_hold[IDX_CMP] = wr_access && paddr == OFS_COMPARE;
    assign wr_hold[IDX_CTL] = wr_access && paddr == OFS_CONTROL;

    generate
        for (genvar g = 0; g < NUM_HOLD; g++) begin : g_hold
            ats_hold u_hold (
                .clk(clk),
                .rst_n(rst_n),
                .async_mode(clock_source_select),
                .wr(wr_hold[g]),
                .wdata(pwdata[DATA_W-1:0]),
                .osc_edge(osc_edge),
                .hold(hold[g]),
                .busy(busy[g]),
                .load(load[g])
            );
        end
    endgenerate

    // Source switches are not guarded; contents may be stale afterwards
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_value <= RST_BYTE;
        end else if (load[IDX_CMP]) begin
            compare_value <= hold[IDX_CMP];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control <= RST_BYTE;
        end else if (load[IDX_CTL]) begin
            timer_control <= hold[IDX_CTL];
        end
    end

    // Any nonzero clock select runs undivided; prescaling lives elsewhere
    assign running = timer_control[BIT_CS_HI:0] != 3'b000;
    // A forced compare acts with the mode bits written alongside it
    assign out_mode = ats_out_mode_t'(load[IDX_CTL] ? hold[IDX_CTL][BIT_MODE_HI:BIT_MODE_LO]
        : timer_control[BIT_MODE_HI:BIT_MODE_LO]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= RST_BYTE;
        end else if (load[IDX_CNT]) begin
            counter_value <= hold[IDX_CNT];
        end else if (tick && running) begin
            counter_value <= counter_value + 8'h01;
        end
    end

    // Copy refreshed one cycle after each oscillator edge, once the count settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_view <= RST_BYTE;
        end else if (osc_edge_d) begin
            counter_view <= counter_value;
        end
    end

    // Match blocked on the first tick after a counter load
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_match <= 1'b0;
        end else if (load[IDX_CNT]) begin
            block_match <= 1'b1;
        end else if (tick && running) begin
            block_match <= 1'b0;
        end
    end

    assign match_evt = tick && running && !load[IDX_CNT]
        && counter_value == compare_value
        && !block_match
        && !busy[IDX_CNT] && !busy[IDX_CMP];
    assign ovf_evt = tick && running && !load[IDX_CNT] && counter_value == CNT_MAX;

    // Output pin follows the timer tick directly; forced compare on control load
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
        end else if (match_evt || (load[IDX_CTL] && hold[IDX_CTL][BIT_FORCE])) begin
            case (out_mode)
                ATS_OUT_TOGGLE: compare_output_pin <= !compare_output_pin;
                ATS_OUT_CLEAR: compare_output_pin <= 1'b0;
                ATS_OUT_SET: compare_output_pin <= 1'b1;
                default: compare_output_pin <= compare_output_pin;
            endcase
        end
    end

    // Event synchroniser into the bus side, used only in oscillator mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_pipe <= '0;
            ovf_pipe <= '0;
        end else begin
            match_pipe <= {match_pipe[SYNC_STAGES-2:0], match_evt};
            ovf_pipe <= {ovf_pipe[SYNC_STAGES-2:0], ovf_evt};
        end
    end

    assign match_set = clock_source_select ? match_pipe[SYNC_STAGES-1] : match_evt;
    assign ovf_set = clock_source_select ? ovf_pipe[SYNC_STAGES-1] : ovf_evt;
    assign flag_clr_cmp = compare_vector_ack
        || (wr_access && paddr == OFS_FLAGS && pwdata[BIT_CMP]);
    assign flag_clr_ovf = overflow_vector_ack
        || (wr_access && paddr == OFS_FLAGS && pwdata[BIT_OVF]);

    // Set beats clear so a coincident event is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_match_flag <= 1'b0;
        end else if (match_set) begin
            compare_match_flag <= 1'b1;
        end else if (flag_clr_cmp) begin
            compare_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag <= 1'b1;
        end else if (flag_clr_ovf) begin
            overflow_flag <= 1'b0;
        end
    end

    assign compare_irq = compare_match_flag && compare_irq_enable;
    assign overflow_irq = overflow_flag && overflow_irq_enable;
    assign wake_cond = compare_irq || overflow_irq;

    // Wake sequencing for sleep with the timer on the oscillator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_state <= ATS_WAKE_IDLE;
            halt_cnt <= 3'b000;
        end else begin
            case (wake_state)
                ATS_WAKE_IDLE: begin
                    if (sleep_active && wake_armed && wake_cond) begin
                        wake_state <= ATS_WAKE_PEND;
                    end
                end
                ATS_WAKE_PEND: begin
                    if (tick) begin
                        wake_state <= ATS_WAKE_HALT;
                        halt_cnt <= 3'(HALT_CYCLES - 1);
                    end
                end
                ATS_WAKE_HALT: begin
                    if (halt_cnt == 3'b000) begin
                        wake_state <= ATS_WAKE_IDLE;
                    end else begin
                        halt_cnt <= halt_cnt - 3'b001;
                    end
                end
                default: wake_state <= ATS_WAKE_IDLE;
            endcase
        end
    end

    assign cpu_halt = wake_state == ATS_WAKE_HALT;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= wake_state == ATS_WAKE_PEND && tick;
        end
    end

    // Re-sleeping within one oscillator cycle of a wake cannot wake again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_armed <= 1'b1;
        end else if (wake_state == ATS_WAKE_PEND && tick) begin
            wake_armed <= 1'b0;
        end else if (osc_edge) begin
            wake_armed <= 1'b1;
        end
    end
endmodule // ats_timer

// [sim/ats_osc_model.sv]
// Crystal oscillator model driving the timer's oscillator pin in bursts.
// Assumes the main clock runs well above four times the oscillator rate.
module ats_osc_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    output logic osc_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial osc_pin = 1'b0;

    // Stands low between bursts so every rising edge is one the bench asked for
    task automatic run_edges(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (HALF) @(posedge clk);
            osc_pin <= 1'b1;
            repeat (HALF) @(posedge clk);
            osc_pin <= 1'b0;
        end
    endtask
endmodule // ats_osc_model

// [sim/ats_timer_asserts.sv]
// Concurrent checks on the timer block's ports: bus answer, wake and halt, flag clearing.
// Assumes zero-wait APB, registered read data and a one-cycle wake pulse.
module ats_timer_asserts
    import ats_pkg::*;
#(
    parameter int HALT_CYCLES = ats_pkg::WAKE_HALT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ats_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_active,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    input wire logic compare_irq,
    input wire logic overflow_irq,
    input wire logic wake_request,
    input wire logic cpu_halt
);
    import ats_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_FLAGS);
    int halt_len;

    // Length of the current halt run, read when it ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halt_len <= 0;
        end else begin
            halt_len <= cpu_halt ? halt_len + 1 : 0;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wake_start;
        $rose(wake_request) && cpu_halt;
    endsequence

    a_ready_access: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_slverr_bad: assert property (s_setup ##0 !mapped |=> pslverr)
        else $error("no error for unmapped address");
    a_slverr_ok: assert property (s_setup ##0 mapped |=> !pslverr)
        else $error("error on mapped address");
    a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved in access phase");
    a_rdata_byte: assert property (prdata[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    a_halt_start: assert property (s_wake_start |=> cpu_halt)
        else $error("halt did not follow wake");
    a_halt_len: assert property ($fell(cpu_halt) |-> halt_len == HALT_CYCLES)
        else $error("halt length wrong");
    a_halt_cause: assert property ($rose(cpu_halt) |-> wake_request)
        else $error("halt without wake");
    a_wake_pulse: assert property (wake_request |=> !wake_request)
        else $error("wake longer than one cycle");
    a_wake_sleep: assert property (wake_request |-> $past(sleep_active))
        else $error("wake while awake");
    a_cmp_clear: assert property ($fell(compare_irq)
        |-> $past(compare_vector_ack || (psel && penable && pwrite)))
        else $error("compare request dropped without cause");
    a_ovf_clear: assert property ($fell(overflow_irq)
        |-> $past(overflow_vector_ack || (psel && penable && pwrite)))
        else $error("overflow request dropped without cause");
endmodule // ats_timer_asserts

bind ats_timer ats_timer_asserts #(.HALT_CYCLES(HALT_CYCLES)) chk_u (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(sleep_active), .compare_vector_ack(compare_vector_ack),
    .overflow_vector_ack(overflow_vector_ack), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .wake_request(wake_request), .cpu_halt(cpu_halt)
);

// [sim/testbench.sv]
// Self-checking bench for the timer block: APB reads and writes with expected values.
// Assumes zero-wait APB and an oscillator model that runs only when asked.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ats_pkg::*;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, sleep_active, cmp_ack, ovf_ack;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, osc, cmp_pin, cmp_irq, ovf_irq, wake, halt;
    logic wake_seen = 1'b0;
    int error_cnt = 0;
    int check_count = 0;
    int halt_cycles = 0;
    logic [31:0] r;
    logic e;

    always #12.5 clk = ~clk;

    ats_timer dut_u (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscillator_input_pin(osc), .sleep_active(sleep_active),
        .compare_vector_ack(cmp_ack), .overflow_vector_ack(ovf_ack),
        .compare_output_pin(cmp_pin), .compare_irq(cmp_irq), .overflow_irq(ovf_irq),
        .wake_request(wake), .cpu_halt(halt)
    );
    ats_osc_model osc_u (.clk(clk), .osc_pin(osc));

    // Leaves sleep once woken, as the processor would
    always @(posedge clk) begin
        if (wake === 1'b1) begin
            wake_seen <= 1'b1;
            sleep_active <= 1'b0;
        end
        if (halt === 1'b1) halt_cycles <= halt_cycles + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(r, {24'h000000, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, sleep_active, cmp_ack, ovf_ack} <= 6'h00;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        settle(3);
        for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 8'h00);
        apb(1'b0, 8'h18, 8'h00);
        check({31'h00000000, e}, 32'h00000001);
        wr(OFS_COUNTER, 8'h10);
        rd_chk(OFS_COUNTER, 8'h10);
        wr(OFS_COMPARE, 8'h55);
        rd_chk(OFS_COMPARE, 8'h55);
        wr(OFS_STATUS, 8'h0F);
        rd_chk(OFS_STATUS, 8'h08);
        wr(OFS_COUNTER, 8'h20);
        rd_chk(OFS_STATUS, 8'h0C);
        wr(OFS_COMPARE, 8'h30);
        rd_chk(OFS_STATUS, 8'h0E);
        rd_chk(OFS_COMPARE, 8'h30);
        osc_u.run_edges(1);
        settle(8);
        rd_chk(OFS_STATUS, 8'h0E);
        osc_u.run_edges(1);
        settle(8);
        rd_chk(OFS_STATUS, 8'h08);
        osc_u.run_edges(1);
        settle(4);
        rd_chk(OFS_COUNTER, 8'h20);
        wr(OFS_CONTROL, 8'h11);
        rd_chk(OFS_STATUS, 8'h09);
        rd_chk(OFS_CONTROL, 8'h11);
        wr(OFS_COMPARE, 8'h24);
        rd_chk(OFS_STATUS, 8'h0B);
        osc_u.run_edges(2);
        settle(8);
        rd_chk(OFS_STATUS, 8'h08);
        rd_chk(OFS_COUNTER, 8'h20);
        osc_u.run_edges(8);
        settle(8);
        rd_chk(OFS_FLAGS, 8'h80);
        check({31'h00000000, cmp_pin}, 32'h00000001);
        wr(OFS_IRQ_EN, 8'h80);
        settle(2);
        check({31'h00000000, cmp_irq}, 32'h00000001);
        @(posedge clk) cmp_ack <= 1'b1;
        @(posedge clk) cmp_ack <= 1'b0;
        settle(2);
        check({31'h00000000, cmp_irq}, 32'h00000000);
        wr(OFS_COUNTER, 8'hFD);
        osc_u.run_edges(2);
        settle(8);
        rd_chk(OFS_STATUS, 8'h08);
        wr(OFS_IRQ_EN, 8'h40);
        @(posedge clk) sleep_active <= 1'b1;
        osc_u.run_edges(6);
        settle(8);
        check({31'h00000000, ovf_irq}, 32'h00000001);
        check({31'h00000000, wake_seen}, 32'h00000001);
        check(32'(halt_cycles), 32'h00000004);
        @(posedge clk) ovf_ack <= 1'b1;
        @(posedge clk) ovf_ack <= 1'b0;
        settle(2);
        check({31'h00000000, ovf_irq}, 32'h00000000);
        wr(OFS_COUNTER, 8'hFE);
        osc_u.run_edges(4);
        settle(8);
        check({31'h00000000, ovf_irq}, 32'h00000001);
        wr(OFS_FLAGS, 8'h40);
        settle(2);
        check({31'h00000000, ovf_irq}, 32'h00000000);
        rd_chk(OFS_FLAGS, 8'h00);
        wr(OFS_CONTROL, 8'hB1);
        rd_chk(OFS_CONTROL, 8'h31);
        osc_u.run_edges(2);
        settle(8);
        check({31'h00000000, cmp_pin}, 32'h00000001);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule // testbench
